// ===== core_pkg.sv
// constants and state layout for the instruction core and its bus slave
// assumes a single clock domain; the oscillator clock drives aclk
package core_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int Q_PER_CYCLE = 4;
  localparam logic [1:0] Q_LAST = 2'(Q_PER_CYCLE - 1);
  localparam int OST_OSC_PERIODS = 1024;
  localparam int OSC_PER_CLK = 1;
  localparam logic [9:0] OST_LAST =
    10'(OST_OSC_PERIODS / OSC_PER_CLK - 1);
  // ----------------------------------------------------------------
  // addresses and encodings
  // ----------------------------------------------------------------
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  localparam logic [6:0] FIRST_IO_PORT = 7'h05;
  localparam logic [13:0] OP_NOP = 14'h0000;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETFIE = 14'h0009;
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [13:0] WATCHDOG_CLEAR_OP = 14'h0064;
  localparam logic [3:0] CLEAR_FILE_GROUP = 4'h1;
  // oscillator modes; codes below OSC_EC are crystal modes
  localparam logic [2:0] OSC_LP = 3'h0;
  localparam logic [2:0] OSC_XT = 3'h1;
  localparam logic [2:0] OSC_HS = 3'h2;
  localparam logic [2:0] OSC_EC = 3'h3;
  localparam logic [2:0] OSC_RC = 3'h4;
  // ----------------------------------------------------------------
  // register map (word index = addr[4:2])
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATE = 3'h1;
  localparam logic [2:0] REG_EVENT = 3'h2;
  localparam logic [2:0] REG_MASK = 3'h3;
  localparam int CTRL_GIE = 0;
  localparam int CTRL_OSC_LSB = 1;
  localparam int EVT_SLEPT = 0;
  localparam int EVT_WOKE = 1;
  localparam int EVT_SLEEP_NOP = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RUN, DOZE, OST} core_state_t;
  typedef struct packed {
    logic [1:0] q;
    core_state_t st;
    logic [9:0] ost;
    logic [12:0] pc;
    logic [13:0] ir;
    logic [7:0] w;
    logic [7:0] opnd;
    logic c, z, to, pd, global_interrupt_enable, early;
    logic [2:0] sp;
    logic [7:0][12:0] stk;
    logic [6:0] fa;
    logic [7:0] fwd;
    logic fwe, fre, pcclr, wclr;
    logic [2:0] osc;
    logic [2:0] evt, msk;
    logic irq;
    logic aw_h, w_h, awr, wr, arr, bv, rv;
    logic [2:0] wa;
    logic [7:0] wd;
    logic ws;
    logic [1:0] bresp, rresp;
    logic [31:0] rd;
  } core_regs_t;
endpackage : core_pkg

// ===== core_sequencer.sv
// instruction decode, sequencing and sleep/wake control of an 8-bit core
// assumes program and file memories read combinationally on the same
// clock, and interrupt sources present enable-and-flag as one level
//
// Overview of operation
// RULE1 - pending interrupt before sleep: sleep acts as nop
// RULE2 - wake during/after sleep: clear watchdog, flags
// RULE3 - after wake, vector if global enable, else continue
// RULE4 - crystal modes wait 1024 oscillator periods on wake
// RULE5 - each instruction is one 14-bit word
// RULE6 - destination bit picks accumulator or file register
// RULE7 - seven-bit direct file address, 0x00 to 0x7F
// RULE8 - bit-select picks one bit of file register
// RULE9 - literal is eight or eleven bits wide
// RULE10 - four oscillator periods make one instruction cycle
// RULE11 - one cycle, two when skipping or branching
// RULE12 - named file register is always read first
// RULE13 - port read clears the pin-change mismatch
// RULE14 - don't-care instruction bits change nothing
// RULE15 - wake ignores global enable; watchdog clear sets flags
// RULE16 - skip or branch discards prefetched word
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module core_sequencer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [4:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [4:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // program memory
  output logic [12:0] pm_addr,
  input wire logic [13:0] pm_data,
  // file registers
  output logic [6:0] fr_addr,
  input wire logic [7:0] fr_rd_data,
  output logic fr_re,
  output logic fr_we,
  output logic [7:0] fr_wr_data,
  // neighbours
  input wire logic int_wake,
  input wire logic wdt_timeout,
  output logic wdt_clear,
  output logic pin_change_clear,
  output logic timeout_flag,
  output logic power_down_flag,
  output logic irq
);
  import core_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  core_regs_t r, n;
  logic [7:0] bit_mask;
  logic exec;
  logic crystal;

  assign exec = (r.st == RUN) && (r.q == Q_LAST);
  assign crystal = r.osc < OSC_EC;

  // one-hot bit select from the instruction
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_mask
      assign bit_mask[i] = (r.ir[9:7] == 3'(i)); // RULE8
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [8:0] sum;
    logic [7:0] v, k, res;
    logic tof, tow, zf, skp, jmp;
    logic [12:0] npc;
    n = r;
    sum = '0;
    v = r.opnd;
    k = r.ir[7:0]; // RULE9
    res = '0;
    tof = 1'b0;
    tow = 1'b0;
    zf = 1'b0;
    skp = 1'b0;
    jmp = 1'b0;
    npc = r.pc + 13'h0001;
    n.fre = 1'b0;
    n.fwe = 1'b0;
    n.pcclr = 1'b0;
    n.wclr = 1'b0;
    // bus slave; the read clear of events runs before new sets
    if (r.bv && bready) n.bv = 1'b0;
    if (r.rv && rready) n.rv = 1'b0;
    if (awvalid && r.awr) begin
      n.aw_h = 1'b1;
      n.wa = awaddr[4:2];
    end
    if (wvalid && r.wr) begin
      n.w_h = 1'b1;
      n.wd = wdata[7:0];
      n.ws = wstrb[0];
    end
    if (n.aw_h && n.w_h && !n.bv) begin
      n.aw_h = 1'b0;
      n.w_h = 1'b0;
      n.bv = 1'b1;
      // the address may have been taken in this very cycle, so use n.wa
      n.bresp = (n.wa > REG_MASK) ? RESP_SLVERR : RESP_OKAY;
      if (n.ws && n.wa == REG_CTRL) begin
        n.global_interrupt_enable = n.wd[CTRL_GIE];
        n.osc = n.wd[CTRL_OSC_LSB +: 3];
      end
      if (n.ws && n.wa == REG_MASK) n.msk = n.wd[2:0];
    end
    if (arvalid && r.arr) begin
      n.rv = 1'b1;
      n.rresp = (araddr[4:2] > REG_MASK) ? RESP_SLVERR : RESP_OKAY;
      case (araddr[4:2])
        REG_CTRL: n.rd = {28'h0, r.osc, r.global_interrupt_enable};
        REG_STATE: n.rd = {3'h0, r.pc, r.w, 3'h0, r.st == DOZE,
                           r.to, r.pd, r.c, r.z};
        REG_EVENT: begin
          n.rd = {29'h0, r.evt};
          n.evt = '0;
        end
        REG_MASK: n.rd = {29'h0, r.msk};
        default: n.rd = '0;
      endcase
    end
    n.awr = !n.aw_h && !n.bv;
    n.wr = !n.w_h && !n.bv;
    n.arr = !n.rv;
    // core sequencing
    case (r.st)
      RUN: begin
        n.q = r.q + 2'h1; // RULE10
        // file address moves only after the write-back cycle has used it
        if (r.q == 2'h0) begin
          n.fa = r.ir[6:0]; // RULE7
          n.fre = 1'b1; // RULE12
          n.pcclr = (r.ir[6:0] == FIRST_IO_PORT); // RULE13
          n.early = int_wake;
        end
        if (r.q == 2'h2) n.opnd = fr_rd_data;
        if (exec) begin
          if (r.ir[13:7] == 7'h00) begin
            case (r.ir)
              OP_SLEEP: begin
                if (r.early) begin
                  n.evt[EVT_SLEEP_NOP] = 1'b1; // RULE1
                end else begin
                  n.wclr = 1'b1; // RULE2
                  n.to = 1'b1;
                  n.pd = 1'b0;
                  n.st = DOZE;
                  n.evt[EVT_SLEPT] = 1'b1;
                end
              end
              WATCHDOG_CLEAR_OP: begin
                n.wclr = 1'b1; // RULE15
                n.to = 1'b1;
                n.pd = 1'b1;
              end
              OP_RETURN, OP_RETFIE: begin
                jmp = 1'b1;
                n.sp = r.sp - 3'h1;
                npc = r.stk[n.sp];
                if (r.ir[0]) n.global_interrupt_enable = 1'b1;
              end
              default: ; // nop, bits 6:5 ignored RULE14
            endcase
          end else begin
            case (r.ir[13:12])
              2'b00: begin
                tof = r.ir[7]; // RULE6
                tow = !r.ir[7];
                zf = 1'b1;
                case (r.ir[11:8])
                  4'h0: begin
                    res = r.w;
                    zf = 1'b0;
                  end
                  CLEAR_FILE_GROUP: res = 8'h00;
                  4'h2: begin
                    sum = {1'b0, v} - {1'b0, r.w};
                    res = sum[7:0];
                    n.c = !sum[8];
                  end
                  4'h3: res = v - 8'h01;
                  4'h4: res = r.w | v;
                  4'h5: res = r.w & v;
                  4'h6: res = r.w ^ v;
                  4'h7: begin
                    sum = {1'b0, v} + {1'b0, r.w};
                    res = sum[7:0];
                    n.c = sum[8];
                  end
                  4'h8: res = v;
                  4'h9: res = ~v;
                  4'ha: res = v + 8'h01;
                  4'hc: begin
                    res = {r.c, v[7:1]};
                    n.c = v[0];
                    zf = 1'b0;
                  end
                  4'hd: begin
                    res = {v[6:0], r.c};
                    n.c = v[7];
                    zf = 1'b0;
                  end
                  4'he: begin
                    res = {v[3:0], v[7:4]};
                    zf = 1'b0;
                  end
                  default: begin
                    // decfsz and incfsz leave the zero flag alone
                    res = r.ir[10] ? v + 8'h01 : v - 8'h01;
                    skp = (res == 8'h00); // RULE11
                    zf = 1'b0;
                  end
                endcase
              end
              2'b01: begin
                case (r.ir[11:10])
                  2'b00: begin
                    res = v & ~bit_mask;
                    tof = 1'b1;
                  end
                  2'b01: begin
                    res = v | bit_mask;
                    tof = 1'b1;
                  end
                  2'b10: skp = (v & bit_mask) == 8'h00;
                  default: skp = (v & bit_mask) != 8'h00;
                endcase
              end
              2'b10: begin
                jmp = 1'b1; // RULE11
                npc = {r.pc[12:11], r.ir[10:0]}; // RULE9
                if (!r.ir[11]) begin
                  n.stk[r.sp] = r.pc;
                  n.sp = r.sp + 3'h1;
                end
              end
              default: begin
                tow = 1'b1;
                zf = 1'b1;
                casez (r.ir[11:8]) // RULE14
                  4'b00??: zf = 1'b0;
                  4'b01??: begin
                    zf = 1'b0;
                    jmp = 1'b1;
                    n.sp = r.sp - 3'h1;
                    npc = r.stk[n.sp];
                  end
                  4'b1000: res = r.w | k;
                  4'b1001: res = r.w & k;
                  4'b1010: res = r.w ^ k;
                  4'b110?: begin
                    sum = {1'b0, k} - {1'b0, r.w};
                    n.c = !sum[8];
                  end
                  4'b111?: begin
                    sum = {1'b0, k} + {1'b0, r.w};
                    n.c = sum[8];
                  end
                  default: tow = 1'b0;
                endcase
                if (r.ir[11:10] != 2'b10) res = zf ? sum[7:0] : k;
              end
            endcase
          end
          // write back and fetch
          n.fwe = tof; // RULE6
          n.fwd = res;
          if (tow) n.w = res;
          if (zf) n.z = (res == 8'h00);
          if (skp && !jmp) npc = r.pc + 13'h0001;
          n.ir = (skp || jmp) ? OP_NOP : pm_data; // RULE5 RULE16
          // an interrupt taken after the current instruction
          if (r.global_interrupt_enable && int_wake && n.st == RUN) begin
            n.stk[n.sp] = (skp || jmp) ? npc : r.pc;
            n.sp = n.sp + 3'h1;
            npc = INT_VECTOR; // RULE3
            n.ir = OP_NOP;
            n.global_interrupt_enable = 1'b0;
          end
          n.pc = (skp || jmp || n.ir == OP_NOP) ? npc : r.pc + 13'h0001;
        end
      end
      DOZE: begin
        n.q = 2'h0;
        // wake needs only enable and flag of a source RULE15
        if (int_wake || wdt_timeout) begin
          n.st = crystal ? OST : RUN; // RULE4
          n.ost = '0;
          n.wclr = 1'b1;
          n.evt[EVT_WOKE] = 1'b1;
          if (!int_wake) n.to = 1'b0;
        end
      end
      OST: begin
        n.ost = r.ost + 10'h001;
        if (r.ost == OST_LAST) n.st = RUN; // RULE4
      end
      default: n.st = RUN;
    endcase
    n.irq = |(n.evt & n.msk);
  end

  // state register; power-up shows both status flags set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.to <= 1'b1;
      r.pd <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready = r.awr;
  assign wready = r.wr;
  assign bvalid = r.bv;
  assign bresp = r.bresp;
  assign arready = r.arr;
  assign rvalid = r.rv;
  assign rdata = r.rd;
  assign rresp = r.rresp;
  assign pm_addr = r.pc;
  assign fr_addr = r.fa;
  assign fr_re = r.fre;
  assign fr_we = r.fwe;
  assign fr_wr_data = r.fwd;
  assign wdt_clear = r.wclr;
  assign pin_change_clear = r.pcclr;
  assign timeout_flag = r.to;
  assign power_down_flag = r.pd;
  assign irq = r.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_sleep_exec;
    exec && r.ir == OP_SLEEP && !(r.global_interrupt_enable && int_wake);
  endsequence
  sequence s_doze_wake;
    r.st == DOZE && (int_wake || wdt_timeout);
  endsequence

  cycle_count_a: assert property ( // RULE10
    r.st == RUN && r.q == 2'h0 |=> r.q == 2'h1 ##1 r.q == 2'h2
    ##1 r.q == Q_LAST) else $error("instruction cycle not four clocks");
  sleep_nop_a: assert property ( // RULE1
    s_sleep_exec and r.early |=> r.pd == $past(r.pd) && !r.wclr
    && r.st == RUN) else $error("sleep with pending interrupt not nop");
  sleep_exec_a: assert property ( // RULE2
    s_sleep_exec and !r.early |=> r.wclr && r.to && !r.pd
    && r.st == DOZE) else $error("sleep did not clear flags");
  wake_delay_a: assert property ( // RULE4
    s_doze_wake |=> (crystal ? r.st == OST : r.st == RUN) && r.wclr)
    else $error("wrong wake path for oscillator mode");
  ost_end_a: assert property ( // RULE4
    r.st == OST && r.ost == OST_LAST |=> r.st == RUN && r.q == 2'h0)
    else $error("start-up delay end wrong");
  vector_jump_a: assert property ( // RULE3
    exec && r.global_interrupt_enable && int_wake && r.ir != OP_SLEEP |=> r.pc == INT_VECTOR
    && r.ir == OP_NOP && !r.global_interrupt_enable) else $error("interrupt vector missed");
  dest_select_a: assert property ( // RULE6
    exec && r.ir[13:12] == 2'b00 && r.ir[11:8] != 4'h0
    |=> r.fwe == $past(r.ir[7])) else $error("destination select wrong");
  file_read_a: assert property ( // RULE12
    r.st == RUN && r.q == 2'h0 |=> r.fre ##1 !r.fre)
    else $error("file read not issued");
  port_clear_a: assert property ( // RULE13
    r.fre |-> r.pcclr == (r.fa == FIRST_IO_PORT))
    else $error("port read did not clear mismatch");
  wdt_clear_a: assert property ( // RULE15
    exec && r.ir == WATCHDOG_CLEAR_OP |=> r.wclr && r.to && r.pd)
    else $error("watchdog clear flags wrong");
  flush_a: assert property ( // RULE16
    exec && r.ir[13:12] == 2'b10 |=> r.ir == OP_NOP)
    else $error("branch did not discard prefetch");
endmodule : core_sequencer

// ===== core_partner.sv
// program and file memory model facing the core
// assumes combinational reads and writes on the clock edge
`timescale 1ns/1ps
module core_partner (
  // clock
  input wire logic aclk,
  // program memory
  input wire logic [12:0] pm_addr,
  output logic [13:0] pm_data,
  // file registers
  input wire logic [6:0] fr_addr,
  input wire logic fr_we,
  input wire logic [7:0] fr_wr_data,
  output logic [7:0] fr_rd_data
);
  logic [13:0] pm [32];
  logic [7:0] fr [128];
  // only 32 words backed; upper addresses alias, enough for the tests
  assign pm_data = pm[pm_addr[4:0]];
  // full seven-bit direct window
  assign fr_rd_data = fr[fr_addr];
  // write lands at the edge of the pulse
  always @(posedge aclk) begin
    if (fr_we) fr[fr_addr] <= fr_wr_data;
  end
endmodule : core_partner

// ===== testbench.sv
// self-checking bench for the instruction core
// assumes core_partner supplies program and file memory
`timescale 1ns/1ps
module testbench;
  import core_pkg::*;
  logic aclk = 0, aresetn = 0, int_wake = 0, wdt_timeout = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic [3:0] wstrb = 0;
  logic [1:0] rs, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, fr_re, fr_we, irq;
  logic wdt_clear, pin_change_clear, timeout_flag, power_down_flag;
  logic [31:0] rdata;
  logic [12:0] pm_addr;
  logic [13:0] pm_data;
  logic [6:0] fr_addr;
  logic [7:0] fr_rd_data, fr_wr_data;
  int n_fail = 0, n_checks = 0, pcc = 0, wdc = 0, n, w0;
  core_sequencer u_core_sequencer (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .pm_addr, .pm_data, .fr_addr, .fr_rd_data, .fr_re, .fr_we,
    .fr_wr_data, .int_wake, .wdt_timeout, .wdt_clear, .pin_change_clear,
    .timeout_flag, .power_down_flag, .irq);
  core_partner u_core_partner (.aclk, .pm_addr, .pm_data, .fr_addr,
    .fr_we, .fr_wr_data, .fr_rd_data);
  // ----------------------------------------------------------------
  // clock, pulse counters, timeout
  // ----------------------------------------------------------------
  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    if (pin_change_clear === 1'b1) pcc <= pcc + 1;
    if (wdt_clear === 1'b1) wdc <= wdc + 1;
  end
  // whole run is under two thousand cycles
  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    conclude();
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // reset for 12 cycles while the memories are loaded
  task automatic boot(bit b);
    logic [13:0] pa [10];
    pa = '{14'h303c, 14'h00a0, 14'h0a20, 14'h0aa0, 14'h17a1, 14'h1fa1,
      14'h30ff, 14'h0185, 14'h0060, OP_SLEEP};
    // memories load once the core's write pulse has been reset away
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 128; i++) u_core_partner.fr[i] = 8'h00;
    for (int i = 0; i < 32; i++) u_core_partner.pm[i] = OP_NOP;
    if (!b) begin
      for (int i = 0; i < 10; i++) u_core_partner.pm[i] = pa[i];
      u_core_partner.fr[5] = 8'h5a;
    end else begin
      u_core_partner.pm[4] = 14'h30aa;
      u_core_partner.pm[5] = WATCHDOG_CLEAR_OP;
      u_core_partner.pm[6] = 14'h2810;
      u_core_partner.pm[16] = OP_SLEEP;
      u_core_partner.pm[17] = 14'h3055;
      u_core_partner.pm[18] = 14'h2810;
    end
    repeat (10) @(posedge aclk);
    aresetn <= 1;
  endtask : boot
  // requests change just after a rising edge; handshakes are judged on
  // the values that stand at the rising edge, before the slave moves
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1;
    awaddr <= a;
    wvalid <= 1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1;
    while (1'b1) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 0;
  endtask : wr
  task automatic rdr(logic [4:0] a);
    @(posedge aclk);
    arvalid <= 1;
    araddr <= a;
    rready <= 1;
    while (1'b1) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 0;
  endtask : rdr
  task automatic wait_pd(logic v);
    for (int i = 0; i < 3000 && power_down_flag !== v; i++)
      @(negedge aclk);
  endtask : wait_pd
  // clocks until the fetch address moves on
  task automatic span(output int c);
    logic [12:0] p;
    p = pm_addr;
    c = 0;
    do begin
      @(negedge aclk);
      c++;
    end while (pm_addr === p && c < 3000);
  endtask : span
  task automatic pulse_wake();
    @(posedge aclk);
    int_wake <= 1;
    @(posedge aclk);
    int_wake <= 0;
  endtask : pulse_wake
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // byte, bit and literal ops, skip over a word, port clear, bad read
  task automatic t_bytes();
    boot(0);
    span(n);
    span(n);
    check("cycle clocks", n, 4);
    wait_pd(0);
    check("f20", u_core_partner.fr[32], 8'h3d);
    check("f21", u_core_partner.fr[33], 8'h80);
    check("port", u_core_partner.fr[5], 8'h00);
    check("port clear", pcc, 1);
    rdr(5'h04);
    check("w", rd[15:8], 8'h3d);
    check("rd resp", rs, RESP_OKAY);
    check("asleep", rd[4], 1'b1);
    rdr(5'h10);
    check("bad resp", rs, RESP_SLVERR);
    $display("t_bytes done");
  endtask : t_bytes
  // interrupt pending before the standby op: it runs as a nop
  task automatic t_nop();
    @(posedge aclk);
    int_wake <= 1;
    boot(1);
    repeat (100) @(negedge aclk);
    w0 = wdc;
    repeat (200) @(negedge aclk);
    check("wdt kept", wdc - w0, 0);
    check("pd", power_down_flag, 1'b1);
    check("to", timeout_flag, 1'b1);
    rdr(5'h08);
    check("nop event", rd[EVT_SLEEP_NOP], 1'b1);
    rdr(5'h04);
    check("w", rd[15:8], 8'h55);
    int_wake <= 0;
    $display("t_nop done");
  endtask : t_nop
  // wake with global enable off, no start-up delay, event interrupt
  task automatic t_ec();
    boot(1);
    wr(5'h00, 32'h6);
    wr(5'h0c, 32'h2);
    check("wr resp", rs, RESP_OKAY);
    wait_pd(0);
    check("to", timeout_flag, 1'b1);
    pulse_wake();
    // the standby op's own clear pulse is already counted here
    w0 = wdc;
    span(n);
    check("no delay", n < 16, 1'b1);
    repeat (40) @(negedge aclk);
    check("wdt pulses", wdc - w0, 2);
    check("irq on", irq, 1'b1);
    rdr(5'h08);
    check("woke", rd[EVT_WOKE], 1'b1);
    @(negedge aclk);
    check("irq off", irq, 1'b0);
    rdr(5'h04);
    check("in line", rd[15:8], 8'h55);
    // a watchdog wake clears the timeout flag
    @(posedge aclk);
    wdt_timeout <= 1;
    @(posedge aclk);
    wdt_timeout <= 0;
    @(negedge aclk);
    check("wdt wake to", timeout_flag, 1'b0);
    $display("t_ec done");
  endtask : t_ec
  // crystal wake with global enable on: delay, then vector
  task automatic t_xt();
    boot(1);
    wr(5'h00, 32'h3);
    wait_pd(0);
    // the source flag stays up until the handler has run
    @(posedge aclk);
    int_wake <= 1;
    span(n);
    check("ost", n >= 1023 && n < 1040, 1'b1);
    wait_pd(1);
    check("clear op pd", power_down_flag, 1'b1);
    check("clear op to", timeout_flag, 1'b1);
    @(posedge aclk);
    int_wake <= 0;
    wait_pd(0);
    rdr(5'h04);
    check("vector", rd[15:8], 8'haa);
    $display("t_xt done");
  endtask : t_xt
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    t_bytes();
    t_nop();
    t_ec();
    t_xt();
    conclude();
  end
endmodule : testbench
